// file: hw/aoc_pkg.sv
// package: register map, field layout and types of the angle output clamp
package aoc_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [3:0]  IDX_LOWER_LIMIT  = 4'hA;
    localparam logic [3:0]  IDX_UPPER_LIMIT  = 4'hB;
    localparam logic [3:0]  IDX_SWITCH_SCALE = 4'hE;
    // status and transfer registers
    localparam logic [3:0]  IDX_ANGLE_IN     = 4'h0;
    localparam logic [3:0]  IDX_OUTPUT_CODE  = 4'h1;
    localparam logic [3:0]  IDX_STATUS       = 4'h2;
    localparam logic [3:0]  IDX_CONTROL      = 4'h3;

    // field layout
    localparam int          DAC_W            = 13;
    localparam int          ANGLE_W          = 16;
    localparam int          SW_ANGLE_LSB     = 6;
    localparam int          SW_ANGLE_W       = 10;
    localparam int          SCALE_HI_W       = 6;

    // dac code limits
    localparam logic [12:0] LOWER_RESERVED_MAX = 13'h00FF;
    localparam logic [12:0] UPPER_VALID_MIN    = 13'h0100;
    localparam logic [12:0] UPPER_VALID_MAX    = 13'h1300;
    localparam logic [12:0] DAC_FULL_SCALE     = 13'h1400;

    // reset values of the configuration words
    localparam logic [15:0] RST_LOWER_LIMIT  = 16'h0100;
    localparam logic [15:0] RST_UPPER_LIMIT  = 16'h1300;
    localparam logic [15:0] RST_SWITCH_SCALE = 16'hFFC1;
    localparam logic [15:0] RST_CONTROL      = 16'h0000;

    // axi answer codes
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // configuration carried to the transfer stage
    typedef struct packed {
        logic [12:0] lower_code;
        logic [12:0] upper_code;
        logic [9:0]  switch_angle;
        logic        falling;
    } aoc_cfg_s;

    // result of the transfer stage
    typedef struct packed {
        logic [12:0] code;
        logic        switched;
        logic        limited;
    } aoc_out_s;

    // slave write states
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_HOLD = 3'b100
    } aoc_wr_e;

endpackage : aoc_pkg

// file: hw/aoc_transfer.sv
// transfer stage: angle to clamped output dac code
`timescale 1ns/1ps
`default_nettype none
module aoc_transfer
(
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // configuration and measured angle
    input  wire aoc_pkg::aoc_cfg_s cfg,
    input  wire logic [15:0]     angle,
    input  wire logic [12:0]     raw_code,
    // registered result
    output aoc_pkg::aoc_out_s    result
);

    // angle folded by slope direction
    logic [15:0] angle_eff;
    // top ten bits compared against the switch angle
    logic [9:0]  angle_top;
    logic        beyond;
    logic        below_lo;
    logic        above_hi;
    logic [12:0] next_code;

    // falling slope mirrors the angle so one compare serves both
    assign angle_eff = cfg.falling ? ~angle : angle;
    assign angle_top = angle_eff[15:6];
    assign beyond    = angle_top > cfg.switch_angle;
    assign below_lo  = raw_code < cfg.lower_code;
    assign above_hi  = raw_code > cfg.upper_code;

    assign next_code = beyond   ? cfg.lower_code :
                       below_lo ? cfg.lower_code :
                       above_hi ? cfg.upper_code : raw_code;

    // result register, one cycle latency
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            result <= '0;
        end
        else
        begin
            result.code     <= next_code;
            result.switched <= beyond;
            result.limited  <= !beyond && (below_lo || above_hi);
        end
    end

endmodule : aoc_transfer
`default_nettype wire

// file: hw/aoc_scale.sv
// scale stage: angle times multiplier plus lower clamp code
`timescale 1ns/1ps
`default_nettype none
module aoc_scale
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // operands
    input  wire logic [15:0] angle,
    input  wire logic [5:0]  scale_high,
    input  wire logic [12:0] lower_code,
    // registered raw code, saturated to 13 bits
    output logic [12:0]      raw_code
);

    // multiplier 6.1 fixed point high part; angle spans 2^16 per 180 deg
    // code = lower + angle*mult*8192/65536 ; mult lsb is 2^-1 here
    logic [21:0] product;
    logic [18:0] offset;
    logic [19:0] sum;
    logic [12:0] next_raw;

    assign product  = angle * scale_high;
    assign offset   = product[21:3] >> 1;
    assign sum      = {1'b0, offset} + {7'h00, lower_code};
    // saturate rather than wrap; the clamp stage bounds it anyway
    assign next_raw = (sum > 20'h01FFF) ? 13'h1FFF : sum[12:0];

    // raw code register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            raw_code <= '0;
        end
        else
        begin
            raw_code <= next_raw;
        end
    end

endmodule : aoc_scale
`default_nettype wire

// file: hw/aoc_top.sv
// top: axi4-lite register bank of the angle output clamp
// Functional notes
// - lower limit: 13-bit code, bits 12..0
// - unused top bits written zero, read zero
// - upper limit: 13-bit code, range 256-4864
// - code 5120 equals full supply
// - scale high bits in 5..0 of word E
// - switch angle in bits 15..6 of word E
// - beyond switch angle output goes lower clamp
`timescale 1ns/1ps
`default_nettype none
module aoc_top
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // measured angle from the angle computer
    input  wire logic [15:0] field_angle,
    // dac drive
    output logic [12:0]      dac_code,
    output logic             dac_switched
);

    // configuration words
    logic [15:0] lower_output_limit;
    logic [15:0] upper_output_limit;
    logic [15:0] switch_angle_and_scale_high;
    logic [15:0] control;
    // captured write halves
    logic [7:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    // write state
    aoc_pkg::aoc_wr_e wr_state;
    aoc_pkg::aoc_wr_e next_wr_state;
    // read side
    logic [31:0] read_word;
    logic        read_ok;
    // stage links
    logic [12:0] raw_code;
    aoc_pkg::aoc_cfg_s cfg;
    aoc_pkg::aoc_out_s result;
    // strike counter of rejected writes
    logic [7:0]  reject_count;

    // word index decode from a byte address
    function automatic logic [3:0] word_index(input logic [7:0] addr);
        word_index = addr[5:2];
    endfunction : word_index

    // mapped-address check, used by both paths
    function automatic logic is_mapped(input logic [7:0] addr);
        logic [3:0] idx;
        idx = word_index(addr);
        is_mapped = (addr[7:6] == 2'b00) && (addr[1:0] == 2'b00) &&
                    ((idx == aoc_pkg::IDX_LOWER_LIMIT)  ||
                     (idx == aoc_pkg::IDX_UPPER_LIMIT)  ||
                     (idx == aoc_pkg::IDX_SWITCH_SCALE) ||
                     (idx == aoc_pkg::IDX_ANGLE_IN)     ||
                     (idx == aoc_pkg::IDX_OUTPUT_CODE)  ||
                     (idx == aoc_pkg::IDX_STATUS)       ||
                     (idx == aoc_pkg::IDX_CONTROL));
    endfunction : is_mapped

    // write decode
    logic [3:0]  w_idx;
    logic        w_mapped;
    logic        w_fire;
    logic [15:0] w_lo16;
    logic        w_lanes;
    logic        w_lower_bad;
    logic        w_upper_bad;
    logic        w_commit;

    assign w_idx    = word_index(aw_addr);
    assign w_mapped = is_mapped(aw_addr);
    assign w_fire   = (wr_state == aoc_pkg::WR_IDLE) && aw_held && w_held;
    assign w_lanes  = w_strb[1:0] == 2'b11;
    // top bits forced to zero on store
    assign w_lo16   = {3'b000, w_data[12:0]};
    assign w_lower_bad = (w_idx == aoc_pkg::IDX_LOWER_LIMIT) &&
                         (w_data[12:0] <= aoc_pkg::LOWER_RESERVED_MAX);
    assign w_upper_bad = (w_idx == aoc_pkg::IDX_UPPER_LIMIT) &&
                         ((w_data[12:0] < aoc_pkg::UPPER_VALID_MIN) ||
                          (w_data[12:0] > aoc_pkg::UPPER_VALID_MAX));
    assign w_commit = w_fire && w_mapped && w_lanes &&
                      !w_lower_bad && !w_upper_bad;

    // channel readies: each half accepted once, in either order
    assign s_axi_awready = !aw_held && (wr_state == aoc_pkg::WR_IDLE);
    assign s_axi_wready  = !w_held && (wr_state == aoc_pkg::WR_IDLE);

    // write state sequencing
    always_comb
    begin
        next_wr_state = wr_state;
        case (wr_state)
            aoc_pkg::WR_IDLE: if (w_fire) next_wr_state = aoc_pkg::WR_RESP;
            aoc_pkg::WR_RESP:
                if (s_axi_bready) next_wr_state = aoc_pkg::WR_IDLE;
            default:          next_wr_state = aoc_pkg::WR_IDLE;
        endcase
    end

    // capture of address and data halves
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (w_fire)
            begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (w_fire)
            begin
                w_held <= 1'b0;
            end
        end
    end

    // write response and state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state     <= aoc_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= aoc_pkg::RESP_OKAY;
        end
        else
        begin
            wr_state <= next_wr_state;
            if (w_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_commit ? aoc_pkg::RESP_OKAY
                                         : aoc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration storage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lower_output_limit          <= aoc_pkg::RST_LOWER_LIMIT;
            upper_output_limit          <= aoc_pkg::RST_UPPER_LIMIT;
            switch_angle_and_scale_high <= aoc_pkg::RST_SWITCH_SCALE;
            control                     <= aoc_pkg::RST_CONTROL;
        end
        else if (w_commit)
        begin
            if (w_idx == aoc_pkg::IDX_LOWER_LIMIT)
                lower_output_limit <= w_lo16;
            else if (w_idx == aoc_pkg::IDX_UPPER_LIMIT)
                upper_output_limit <= w_lo16;
            else if (w_idx == aoc_pkg::IDX_SWITCH_SCALE)
                switch_angle_and_scale_high <= w_data[15:0];
            else if (w_idx == aoc_pkg::IDX_CONTROL)
                control <= {15'h0000, w_data[0]};
        end
    end

    // refused-write counter, saturating; shows misuse by the host
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            reject_count <= 8'h00;
        else if (w_fire && !w_commit && (reject_count != 8'hFF))
            reject_count <= reject_count + 8'h01;
    end

    // read decode
    logic [3:0] r_idx;
    assign r_idx   = word_index(s_axi_araddr);
    assign read_ok = is_mapped(s_axi_araddr);
    assign s_axi_arready = !s_axi_rvalid;

    // top bits read back as zero
    assign read_word =
        (r_idx == aoc_pkg::IDX_LOWER_LIMIT)  ? {16'h0000, lower_output_limit} :
        (r_idx == aoc_pkg::IDX_UPPER_LIMIT)  ? {16'h0000, upper_output_limit} :
        (r_idx == aoc_pkg::IDX_SWITCH_SCALE) ?
            {16'h0000, switch_angle_and_scale_high} :
        (r_idx == aoc_pkg::IDX_ANGLE_IN)     ? {16'h0000, field_angle} :
        (r_idx == aoc_pkg::IDX_OUTPUT_CODE)  ? {19'h00000, result.code} :
        (r_idx == aoc_pkg::IDX_STATUS)       ?
            {22'h000000, reject_count, result.limited, result.switched} :
        (r_idx == aoc_pkg::IDX_CONTROL)      ? {16'h0000, control} :
        32'h0000_0000;

    // read answer, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= aoc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_ok ? read_word : 32'h0000_0000;
            s_axi_rresp  <= read_ok ? aoc_pkg::RESP_OKAY
                                    : aoc_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // transfer configuration: limit codes, switch angle field of word E, slope bit
    assign cfg.lower_code   = lower_output_limit[12:0];
    assign cfg.upper_code   = upper_output_limit[12:0];
    assign cfg.switch_angle =
        switch_angle_and_scale_high[15:aoc_pkg::SW_ANGLE_LSB];
    assign cfg.falling      = control[0];

    // scale high bits feed the multiplier
    aoc_scale u_scale
    (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .angle      (field_angle),
        .scale_high (switch_angle_and_scale_high[5:0]),
        .lower_code (lower_output_limit[12:0]),
        .raw_code   (raw_code)
    );

    // clamp and switch stage
    aoc_transfer u_transfer
    (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cfg      (cfg),
        .angle    (field_angle),
        .raw_code (raw_code),
        .result   (result)
    );

    // dac outputs from the registered result
    assign dac_code     = result.code;
    assign dac_switched = result.switched;

endmodule : aoc_top
`default_nettype wire

// file: verification/aoc_checker.sv
// checker: readback and output clamp properties of the register bank
`timescale 1ns/1ps
`default_nettype none
module aoc_checker
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // output side
    input wire logic [15:0] field_angle,
    input wire logic [12:0] dac_code,
    input wire logic        dac_switched
);
    localparam logic [7:0] A_LO = 8'h28;
    localparam logic [7:0] A_HI = 8'h2C;
    localparam logic [7:0] A_SW = 8'h38;
    logic [7:0]  wa;      // write address taken
    logic [15:0] wd;      // write data taken
    logic [7:0]  ra;      // read address taken
    logic [15:0] lo;      // shadow lower limit
    logic [15:0] hi;      // shadow upper limit
    logic [15:0] e;       // shadow switch and scale word
    logic [15:0] a1;      // angle one cycle back
    logic        f;       // shadow falling slope bit
    logic [2:0]  quiet;   // cycles since a write answer
    logic        wr_ok;   // accepted write completes
    logic        settled; // pipeline has caught up with the words
    assign wr_ok = s_axi_bvalid && s_axi_bready
                   && s_axi_bresp == aoc_pkg::RESP_OKAY;
    assign settled = quiet == 3'h7;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // shadows follow accepted writes only, so refusals show up
    always_ff @(posedge aclk)
    begin
        a1 <= field_angle;
        if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[15:0];
        if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
        if (!aresetn)
        begin
            lo    <= aoc_pkg::RST_LOWER_LIMIT;
            hi    <= aoc_pkg::RST_UPPER_LIMIT;
            e     <= aoc_pkg::RST_SWITCH_SCALE;
            f     <= 1'b0;
            quiet <= 3'h0;
        end
        else
        begin
            quiet <= s_axi_bvalid ? 3'h0 : quiet + {2'h0, !settled};
            if (wr_ok && wa == A_LO) lo <= {3'h0, wd[12:0]};
            if (wr_ok && wa == A_HI) hi <= {3'h0, wd[12:0]};
            if (wr_ok && wa == A_SW) e <= wd;
            if (wr_ok && wa == 8'h0C) f <= wd[0];
        end
    end

    AST_RDATA_TOP : assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_LOWER_READ : assert property (
        s_axi_rvalid && ra == A_LO |-> s_axi_rdata[15:0] == lo
        && s_axi_rresp == aoc_pkg::RESP_OKAY)
        else $error("lower limit readback wrong");
    AST_UPPER_READ : assert property (
        s_axi_rvalid && ra == A_HI |-> s_axi_rdata[15:0] == hi
        && hi >= 16'h0100 && hi <= 16'h1300)
        else $error("upper limit readback wrong");
    AST_SCALE_READ : assert property (
        s_axi_rvalid && ra == A_SW |-> s_axi_rdata[5:0] == e[5:0])
        else $error("scale bits readback wrong");
    AST_ANGLE_READ : assert property (
        s_axi_rvalid && ra == A_SW |-> s_axi_rdata[15:6] == e[15:6])
        else $error("switch angle readback wrong");
    AST_SWITCH_FLAG : assert property (
        settled |-> dac_switched == ((a1[15:6] ^ {10{f}}) > e[15:6]))
        else $error("switch flag does not follow angle");
    AST_SWITCH_CODE : assert property (
        settled && dac_switched |-> dac_code == lo[12:0])
        else $error("switched output not at lower limit");
    AST_CLAMP_RANGE : assert property (
        settled && !dac_switched |-> dac_code >= lo[12:0]
        && dac_code <= hi[12:0])
        else $error("output code outside limits");
    AST_FULL_SCALE : assert property (
        dac_code < aoc_pkg::DAC_FULL_SCALE)
        else $error("output code at or above full supply");
    COV_REFUSED : cover property (s_axi_bvalid && s_axi_bresp != 2'h0);
    COV_SWITCHED : cover property (settled && dac_switched);
    COV_LIMITED : cover property (settled && dac_code == hi[12:0]);
endmodule : aoc_checker

bind aoc_top aoc_checker aoc_checker_inst
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .field_angle, .dac_code, .dac_switched
);
`default_nettype wire

// file: verification/aoc_host.sv
// host model: programming master on the register bus
`timescale 1ns/1ps
`default_nettype none
module aoc_host
(
    // clock
    input  wire logic        aclk,
    // write channels
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // read channels
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    // a wait ran out
    output logic             hung
);
    int stall = 0; // cycles before an answer is accepted

    // idle bus at time zero
    initial
    begin
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 48'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, hung} = 3'h0;
        s_axi_wstrb = 4'hF;
    end

    // one write; released lines toggle so stale values never match
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (n < 200)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_awready) s_axi_awaddr <= ~s_axi_awaddr;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_wready) s_axi_wdata <= ~s_axi_wdata;
            s_axi_bready <= n >= stall;
        end
        r = s_axi_bresp;
        if (!(s_axi_bvalid && s_axi_bready)) hung <= 1'b1;
        s_axi_bready <= 1'b0;
    endtask : wr

    // one read
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (n < 200)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_arready) s_axi_araddr <= ~s_axi_araddr;
            s_axi_rready <= n >= stall;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (!(s_axi_rvalid && s_axi_rready)) hung <= 1'b1;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : aoc_host
`default_nettype wire

// file: verification/angle_output_clamp_config_tb_top.sv
// testbench: register bank and output transfer against a model
`timescale 1ns/1ps
`default_nettype none
module angle_output_clamp_config_tb_top;
    localparam logic [7:0] A_LO = 8'h28;
    localparam logic [7:0] A_HI = 8'h2C;
    localparam logic [7:0] A_SW = 8'h38;
    logic        aclk, aresetn, hung, dac_switched;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [12:0] dac_code;
    logic [15:0] field_angle, a;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd_data;
    int          lo, hi, e, m2, sw, i, miscompares, comparisons;
    bit          fall; // control slope bit
    // first seven refused, the rest accepted
    logic [7:0]  wa_t [11] = '{8'h28, 8'h28, 8'h2C, 8'h2C, 8'h2C, 8'h30,
                               8'h29, 8'h28, 8'h2C, 8'h28, 8'h2C};
    logic [15:0] wd_t [11] = '{16'h0000, 16'h00FF, 16'h00FF, 16'h1301,
                               16'h1400, 16'h0001, 16'h0200, 16'h0100,
                               16'h1300, 16'h0200, 16'h1200};
    logic [15:0] at [7] = '{16'h0000, 16'h1234, 16'hBFFF, 16'hC000,
                            16'hC03F, 16'hC040, 16'hFFFF};

    aoc_top aoc_top_inst
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .field_angle, .dac_code,
        .dac_switched
    );
    aoc_host aoc_host_inst
    (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .hung
    );

    always #20 aclk = ~aclk;

    // a stuck handshake ends the run
    always @(posedge hung)
    begin
        miscompares++;
        results();
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // expected {switched, code}; switch test first, then limits
    function automatic logic [13:0] dac_exp(input logic [15:0] x);
        int r;
        r = lo + ((x * e[5:0]) >> 4);
        if ((x[15:6] ^ {10{fall}}) > e[15:6])
            return {1'b1, lo[12:0]};
        return {1'b0, 13'(r > hi ? hi : r)};
    endfunction : dac_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic rchk(input logic [7:0] x);
        logic [31:0] d;
        logic [1:0]  r;
        bit          m;
        m = x == A_LO || x == A_HI || x == A_SW;
        aoc_host_inst.rd(x, d, r);
        check(r, m ? aoc_pkg::RESP_OKAY : aoc_pkg::RESP_SLVERR);
        check(d, x == A_LO ? lo : x == A_HI ? hi : x == A_SW ? e : 0);
    endtask : rchk

    task automatic wchk(input logic [7:0] x, input logic [15:0] d,
                        input bit bad);
        logic [1:0] r;
        aoc_host_inst.wr(x, d, r);
        check(r, bad ? aoc_pkg::RESP_SLVERR : aoc_pkg::RESP_OKAY);
        if (!bad && x == A_LO) lo = d;
        if (!bad && x == A_HI) hi = d;
        if (!bad && x == A_SW) e = d;
        rchk(x);
    endtask : wchk

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        lo = aoc_pkg::RST_LOWER_LIMIT;
        hi = aoc_pkg::RST_UPPER_LIMIT;
        e  = aoc_pkg::RST_SWITCH_SCALE;
        rchk(A_LO);
        rchk(A_HI);
        rchk(A_SW);
    endtask : do_reset

    task automatic results;
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        aclk        = 1'b0;
        aresetn     = 1'b0;
        field_angle = 16'h0000;
        seed        = 32'h26F2;
        miscompares = 0;
        comparisons = 0;
        do_reset();
        rchk(8'h10);
        for (i = 0; i < 11; i++)
        begin
            aoc_host_inst.stall = i % 3;
            wchk(wa_t[i], wd_t[i], i < 7);
        end
        aoc_host_inst.rd(8'h08, rd_data, rd_resp);
        check(rd_data, 32'h0000_001C);
        m2 = (hi - lo) * 360 / (8192 * 90);
        sw = 512 + 1024 * (hi - lo) / (8192 * m2);
        wchk(A_SW, {sw[9:0], m2[5:0]}, 1'b0);
        for (i = 0; i < 27; i++)
        begin
            seed = lfsr(seed);
            a = i < 7 ? at[i] : seed[15:0];
            field_angle <= a;
            repeat (3) @(posedge aclk);
            check({dac_switched, dac_code}, dac_exp(a));
        end
        // falling slope mirrors the switch compare
        aoc_host_inst.wr(8'h0C, 16'h0001, rd_resp);
        fall = 1'b1;
        for (i = 0; i < 2; i++)
        begin
            a = i ? 16'h4000 : 16'h3F00;
            field_angle <= a;
            repeat (3) @(posedge aclk);
            check({dac_switched, dac_code}, dac_exp(a));
        end
        do_reset();
        results();
    end
endmodule : angle_output_clamp_config_tb_top
`default_nettype wire
